//--- src/amd_pkg.sv
// Purpose: Shared constants and types for the address mark detector
// Assumes: System clock of 100 MHz, read clock from the data separator
// Notes: Offsets do not exist; the block has no software registers
package amd_pkg;
  localparam int unsigned AMD_SHIFT_LEN = 8;
  localparam logic [7:0] AMD_DATA_MARK = 8'hA1;
  localparam logic [7:0] AMD_CLOCK_MARK = 8'h0A;
  localparam logic [7:0] AMD_SHIFT_RESET = 8'h00;
  localparam int unsigned AMD_FIFO_WIDTH = 1;
  localparam int unsigned AMD_FIFO_DEPTH = 8;
  // Pin order in the synchroniser bank: {clear_n, set_edge, enable}
  localparam int unsigned AMD_PIN_COUNT = 3;
  localparam int unsigned AMD_PIN_ENABLE = 0;
  localparam int unsigned AMD_PIN_SET_EDGE = 1;
  localparam int unsigned AMD_PIN_CLEAR_N = 2;
  localparam logic [2:0] AMD_PIN_RESET = 3'h4;
  localparam logic AMD_SPARE_RESET = 1'b1;
  // Link side reset held until this counter bit sets, 64 system cycles
  localparam int unsigned AMD_LINK_RESET_BIT = 6;
  // Delayed bit clock timing
  localparam int unsigned AMD_CLOCK_NS = 10;
  localparam int unsigned AMD_BIT_HIGH_NS = 20;
  localparam int unsigned AMD_BIT_HIGH_CYC = (AMD_BIT_HIGH_NS + AMD_CLOCK_NS - 1) / AMD_CLOCK_NS;
  localparam logic [1:0] AMD_BIT_LAST = 2'(AMD_BIT_HIGH_CYC - 1);
  typedef enum logic [1:0]
  {
    AMD_IDLE = 2'h0,
    AMD_HIGH = 2'h1,
    AMD_LOW = 2'h3
  } amd_drain_e;
endpackage

//--- src/amd_async_fifo.sv
// Purpose: Dual-clock FIFO carrying delayed data bits to the system clock
// Assumes: Write side reset released while the read clock runs
// Notes: Gray pointers cross in two flops each way
`timescale 1ns/1ns
module amd_async_fifo
#(
  parameter int unsigned WIDTH = 1,
  parameter int unsigned DEPTH = 8
)
(
  input wire logic i_wr_clock,
  input wire logic i_wr_resetn,
  input wire logic i_wr_valid,
  input wire logic [WIDTH-1:0] i_wr_data,
  output logic o_wr_ready,
  input wire logic i_clock,
  input wire logic i_resetn,
  output logic o_rd_valid,
  output logic [WIDTH-1:0] o_rd_data,
  input wire logic i_rd_ready
);
  localparam int unsigned AW = $clog2(DEPTH);

  function automatic logic [AW:0] bin2gray(input logic [AW:0] b);
    bin2gray = b ^ (b >> 1);
  endfunction

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wbin_reg, wgray_reg, rgray_s1_reg, rgray_s2_reg;
  logic [AW:0] rbin_reg, rgray_reg, wgray_s1_reg, wgray_s2_reg;
  logic [AW:0] wbin_next, rbin_next;
  logic wr_fire, rd_fire;

  // Full when the far pointer differs only in its two top bits
  assign o_wr_ready = (wgray_reg != {~rgray_s2_reg[AW:AW-1], rgray_s2_reg[AW-2:0]});
  assign o_rd_valid = (rgray_reg != wgray_s2_reg);
  assign o_rd_data = mem[rbin_reg[AW-1:0]];
  assign wr_fire = i_wr_valid && o_wr_ready;
  assign rd_fire = i_rd_ready && o_rd_valid;
  assign wbin_next = wbin_reg + (AW+1)'(1);
  assign rbin_next = rbin_reg + (AW+1)'(1);

  // Falling edge matches the shifting edge of the read clock
  always_ff @(negedge i_wr_clock)
  begin
    if (wr_fire)
    begin
      mem[wbin_reg[AW-1:0]] <= i_wr_data;
    end
  end

  always_ff @(negedge i_wr_clock)
  begin
    if (!i_wr_resetn)
    begin
      wbin_reg <= '0;
      wgray_reg <= '0;
      rgray_s1_reg <= '0;
      rgray_s2_reg <= '0;
    end
    else
    begin
      rgray_s1_reg <= rgray_reg;
      rgray_s2_reg <= rgray_s1_reg;
      if (wr_fire)
      begin
        wbin_reg <= wbin_next;
        wgray_reg <= bin2gray(wbin_next);
      end
    end
  end

  always_ff @(posedge i_clock)
  begin
    if (!i_resetn)
    begin
      rbin_reg <= '0;
      rgray_reg <= '0;
      wgray_s1_reg <= '0;
      wgray_s2_reg <= '0;
    end
    else
    begin
      wgray_s1_reg <= wgray_reg;
      wgray_s2_reg <= wgray_s1_reg;
      if (rd_fire)
      begin
        rbin_reg <= rbin_next;
        rgray_reg <= bin2gray(rbin_next);
      end
    end
  end
endmodule

//--- src/amd_mark_detector.sv
// Purpose: Address mark detector with delayed data stream and spare flip-flop
// Assumes: Read clock keeps running for a few edges after enable drops
// Notes: Operation
`timescale 1ns/1ns
module amd_mark_detector
  import amd_pkg::*;
(
  input wire logic i_clock,
  input wire logic i_resetn,
  input wire logic i_read_clock,
  input wire logic i_serial_data,
  input wire logic i_serial_clock_bits,
  input wire logic i_detect_enable,
  input wire logic i_spare_latch_set_edge,
  input wire logic i_spare_clear_n,
  input wire logic i_sink_ready,
  output logic o_mark_found,
  output logic o_mark_found_n,
  output logic o_delayed_bit_clock,
  output logic o_delayed_data,
  output logic o_spare_latch_out,
  output logic o_data_pattern_probe_n,
  output logic o_clock_pattern_probe_n,
  output logic o_stream_overrun
);
  // System-domain pin synchronisers
  logic [AMD_PIN_COUNT-1:0] pin_in;
  logic [AMD_PIN_COUNT-1:0] pin_s1_reg, pin_s2_reg, pin_s3_reg, pin_level_reg;
  logic en_reg;
  assign pin_in = {i_spare_clear_n, i_spare_latch_set_edge, i_detect_enable};
  assign en_reg = pin_level_reg[AMD_PIN_ENABLE];

  genvar gi;
  generate
    for (gi = 0; gi < AMD_PIN_COUNT; gi++)
    begin : g_pin
      always_ff @(posedge i_clock)
      begin
        if (!i_resetn)
        begin
          pin_s1_reg[gi] <= AMD_PIN_RESET[gi];
          pin_s2_reg[gi] <= AMD_PIN_RESET[gi];
          pin_s3_reg[gi] <= AMD_PIN_RESET[gi];
          pin_level_reg[gi] <= AMD_PIN_RESET[gi];
        end
        else
        begin
          pin_s1_reg[gi] <= pin_in[gi];
          pin_s2_reg[gi] <= pin_s1_reg[gi];
          pin_s3_reg[gi] <= pin_s2_reg[gi];
          // Accept a change only once the later stages agree
          if (pin_s2_reg[gi] == pin_s3_reg[gi])
          begin
            pin_level_reg[gi] <= pin_s3_reg[gi];
          end
        end
      end
    end
  endgenerate

  // Link domain, clocked on the falling read clock edge
  logic lrst_s1_reg, lrst_s2_reg, len_s1_reg, len_s2_reg, link_active;
  logic [AMD_SHIFT_LEN-1:0] data_sr_reg, clock_sr_reg;
  logic data_hit, clock_hit, mark_link_reg, overrun_link_reg;
  logic data_tog_reg, clock_tog_reg, push, wr_ready;
  // Stretched so a slow read clock still sees the reset on three falling edges
  logic [AMD_LINK_RESET_BIT:0] lrst_cnt_reg;

  always_ff @(negedge i_read_clock)
  begin
    lrst_s1_reg <= lrst_cnt_reg[AMD_LINK_RESET_BIT];
    lrst_s2_reg <= lrst_s1_reg;
  end

  always_ff @(negedge i_read_clock)
  begin
    if (!lrst_s2_reg)
    begin
      len_s1_reg <= 1'b0;
      len_s2_reg <= 1'b0;
    end
    else
    begin
      len_s1_reg <= en_reg;
      len_s2_reg <= len_s1_reg;
    end
  end

  assign link_active = len_s2_reg;
  assign data_hit = (data_sr_reg == AMD_DATA_MARK);
  assign clock_hit = (clock_sr_reg == AMD_CLOCK_MARK);
  assign push = link_active && mark_link_reg;

  always_ff @(negedge i_read_clock)
  begin
    if (!lrst_s2_reg || !link_active)
    begin
      data_sr_reg <= AMD_SHIFT_RESET;
      clock_sr_reg <= AMD_SHIFT_RESET;
    end
    else
    begin
      data_sr_reg <= {data_sr_reg[AMD_SHIFT_LEN-2:0], i_serial_data};
      clock_sr_reg <= {clock_sr_reg[AMD_SHIFT_LEN-2:0], i_serial_clock_bits};
    end
  end

  always_ff @(negedge i_read_clock)
  begin
    if (!lrst_s2_reg || !link_active)
    begin
      mark_link_reg <= 1'b0;
      overrun_link_reg <= 1'b0;
    end
    else
    begin
      if (data_hit && clock_hit)
      begin
        mark_link_reg <= 1'b1;
      end
      // Serial stream cannot stall, so a full buffer loses the bit
      if (push && !wr_ready)
      begin
        overrun_link_reg <= 1'b1;
      end
    end
  end

  // Toggles carry probe events across the clock boundary
  always_ff @(negedge i_read_clock)
  begin
    if (!lrst_s2_reg)
    begin
      data_tog_reg <= 1'b0;
      clock_tog_reg <= 1'b0;
    end
    else
    begin
      data_tog_reg <= data_tog_reg ^ (link_active && data_hit);
      clock_tog_reg <= clock_tog_reg ^ (link_active && clock_hit);
    end
  end

  // Delayed bit stream buffer
  logic rd_valid, rd_data, rd_ready;
  amd_async_fifo #(
    .WIDTH(AMD_FIFO_WIDTH),
    .DEPTH(AMD_FIFO_DEPTH)
  ) u_fifo (
    .i_wr_clock(i_read_clock),
    .i_wr_resetn(lrst_s2_reg),
    .i_wr_valid(push),
    .i_wr_data(data_sr_reg[AMD_SHIFT_LEN-1]),
    .o_wr_ready(wr_ready),
    .i_clock(i_clock),
    .i_resetn(i_resetn),
    .o_rd_valid(rd_valid),
    .o_rd_data(rd_data),
    .i_rd_ready(rd_ready)
  );

  // Level and toggle crossings into the system domain
  logic mark_s1_reg, mark_s2_reg, ovr_s1_reg, ovr_s2_reg;
  logic [2:0] dtog_reg, ctog_reg;
  always_ff @(posedge i_clock)
  begin
    if (!i_resetn)
    begin
      mark_s1_reg <= 1'b0;
      mark_s2_reg <= 1'b0;
      ovr_s1_reg <= 1'b0;
      ovr_s2_reg <= 1'b0;
      dtog_reg <= 3'h0;
      ctog_reg <= 3'h0;
      lrst_cnt_reg <= '0;
    end
    else
    begin
      mark_s1_reg <= mark_link_reg;
      mark_s2_reg <= mark_s1_reg;
      ovr_s1_reg <= overrun_link_reg;
      ovr_s2_reg <= ovr_s1_reg;
      dtog_reg <= {dtog_reg[1:0], data_tog_reg};
      ctog_reg <= {ctog_reg[1:0], clock_tog_reg};
      lrst_cnt_reg <= lrst_cnt_reg + (AMD_LINK_RESET_BIT+1)'(!lrst_cnt_reg[AMD_LINK_RESET_BIT]);
    end
  end

  always_ff @(posedge i_clock)
  begin
    if (!i_resetn)
    begin
      o_mark_found <= 1'b0;
      o_mark_found_n <= 1'b1;
      o_stream_overrun <= 1'b0;
      o_data_pattern_probe_n <= 1'b1;
      o_clock_pattern_probe_n <= 1'b1;
    end
    else
    begin
      o_mark_found <= en_reg && mark_s2_reg;
      o_mark_found_n <= !(en_reg && mark_s2_reg);
      o_stream_overrun <= en_reg && ovr_s2_reg;
      o_data_pattern_probe_n <= !(en_reg && (dtog_reg[1] ^ dtog_reg[2]));
      o_clock_pattern_probe_n <= !(en_reg && (ctog_reg[1] ^ ctog_reg[2]));
    end
  end

  // Drain: one bit clock pulse per buffered bit
  amd_drain_e state_reg;
  logic [1:0] cnt_reg;
  // Flush stale bits while disabled
  assign rd_ready = rd_valid && (!en_reg || (state_reg == AMD_IDLE && i_sink_ready));

  always_ff @(posedge i_clock)
  begin
    if (!i_resetn || !en_reg)
    begin
      state_reg <= AMD_IDLE;
      cnt_reg <= 2'h0;
      o_delayed_bit_clock <= 1'b0;
      o_delayed_data <= 1'b0;
    end
    else
    begin
      case (state_reg)
        AMD_IDLE:
        begin
          if (rd_ready)
          begin
            o_delayed_data <= rd_data;
            o_delayed_bit_clock <= 1'b1;
            cnt_reg <= 2'h0;
            state_reg <= AMD_HIGH;
          end
        end
        AMD_HIGH:
        begin
          cnt_reg <= cnt_reg + 2'h1;
          if (cnt_reg == AMD_BIT_LAST)
          begin
            o_delayed_bit_clock <= 1'b0;
            cnt_reg <= 2'h0;
            state_reg <= AMD_LOW;
          end
        end
        AMD_LOW:
        begin
          cnt_reg <= cnt_reg + 2'h1;
          if (cnt_reg == AMD_BIT_LAST)
          begin
            cnt_reg <= 2'h0;
            state_reg <= AMD_IDLE;
          end
        end
        default:
        begin
          state_reg <= AMD_IDLE;
        end
      endcase
    end
  end

  // Spare flip-flop; clear dominates the set edge
  logic set_prev_reg;
  always_ff @(posedge i_clock)
  begin
    if (!i_resetn)
    begin
      set_prev_reg <= 1'b0;
      o_spare_latch_out <= AMD_SPARE_RESET;
    end
    else
    begin
      set_prev_reg <= pin_level_reg[AMD_PIN_SET_EDGE];
      if (!pin_level_reg[AMD_PIN_CLEAR_N])
      begin
        o_spare_latch_out <= 1'b1;
      end
      else if (pin_level_reg[AMD_PIN_SET_EDGE] && !set_prev_reg)
      begin
        o_spare_latch_out <= 1'b0;
      end
    end
  end

  default clocking cb @(posedge i_clock);
  endclocking
  default disable iff (!i_resetn);

  a_enable_low_idle: assert property (!en_reg |=> !o_mark_found && o_mark_found_n
    && !o_delayed_bit_clock && !o_delayed_data)
    else $error("outputs active while detection disabled");
  a_mark_pair_match: assert property (o_mark_found == !o_mark_found_n)
    else $error("mark outputs not complementary");
  a_mark_held_on: assert property (o_mark_found && en_reg |=> o_mark_found)
    else $error("mark output dropped while enabled");
  a_clock_after_mark: assert property ($rose(o_delayed_bit_clock) |-> o_mark_found)
    else $error("bit clock started before a mark");
  a_bit_pulse_width: assert property (disable iff (!i_resetn || !en_reg)
    $rose(o_delayed_bit_clock) |-> o_delayed_bit_clock[*2] ##1 !o_delayed_bit_clock[*2])
    else $error("bit clock pulse has wrong shape");
  a_data_steady_high: assert property (o_delayed_bit_clock && $past(o_delayed_bit_clock)
    |-> $stable(o_delayed_data))
    else $error("delayed data moved during bit clock high");
  a_spare_set_edge: assert property (pin_level_reg[AMD_PIN_CLEAR_N]
    && pin_level_reg[AMD_PIN_SET_EDGE] && !set_prev_reg |=> !o_spare_latch_out)
    else $error("spare output not set low on rising edge");
  a_spare_clear_low: assert property (!pin_level_reg[AMD_PIN_CLEAR_N]
    |=> o_spare_latch_out)
    else $error("spare output not forced high by clear");
  a_probe_one_cycle: assert property (!o_data_pattern_probe_n |=> o_data_pattern_probe_n)
    else $error("data probe pulse longer than a cycle");
  a_data_shift_in: assert property (@(negedge i_read_clock) disable iff (!lrst_s2_reg)
    link_active |=> data_sr_reg[0] == $past(i_serial_data))
    else $error("data bit not shifted in");
  a_clock_shift_in: assert property (@(negedge i_read_clock) disable iff (!lrst_s2_reg)
    link_active |=> clock_sr_reg[0] == $past(i_serial_clock_bits))
    else $error("clock bit not shifted in");
  a_pattern_sets_mark: assert property (@(negedge i_read_clock) disable iff (!lrst_s2_reg)
    link_active && data_hit && clock_hit |=> mark_link_reg || !link_active)
    else $error("matched pattern did not set mark");
endmodule

//--- verification/amd_separator_model.sv
// Purpose: Data separator model: read clock and NRZ data/clock bit pairs
// Assumes: Read clock runs free, as a separator window clock does
// Notes: Idle lines toggle each bit so no stale value lingers
`timescale 1ns/1ns
module amd_separator_model
(
  output logic o_read_clock,
  output logic o_serial_data,
  output logic o_serial_clock_bits
);
  logic busy;
  initial
  begin
    o_read_clock = 1'b0;
    o_serial_data = 1'b0;
    o_serial_clock_bits = 1'b1;
    busy = 1'b0;
    #3;
    forever #40 o_read_clock = ~o_read_clock;
  end
  always @(posedge o_read_clock)
  begin
    if (!busy)
    begin
      #1;
      o_serial_data = ~o_serial_data;
      o_serial_clock_bits = ~o_serial_clock_bits;
    end
  end
  // Change after rising edge so bits are stable at the falling shift edge
  task automatic send(input logic [7:0] data, input logic [7:0] clks);
    busy = 1'b1;
    for (int i = 7; i >= 0; i--)
    begin
      @(posedge o_read_clock);
      #1;
      o_serial_data = data[i];
      o_serial_clock_bits = clks[i];
    end
    @(negedge o_read_clock);
    busy = 1'b0;
  endtask
endmodule

//--- verification/amd_mark_detector_bench.sv
// Purpose: Self-checking bench for the address mark detector
// Assumes: Separator model supplies the read clock and serial bits
// Notes: Bench acts as the serial-to-parallel sink
`timescale 1ns/1ns
module amd_mark_detector_bench import amd_pkg::*;
;
  typedef struct {logic [7:0] d; logic [7:0] c; logic m; logic dp; logic cp;} amd_row_s;
  amd_row_s rows [5] = '{'{AMD_DATA_MARK, AMD_CLOCK_MARK, 1'b1, 1'b1, 1'b1},
    '{AMD_DATA_MARK, 8'h00, 1'b0, 1'b1, 1'b0}, '{8'h00, AMD_CLOCK_MARK, 1'b0, 1'b0, 1'b1},
    '{8'hA0, AMD_CLOCK_MARK, 1'b0, 1'b0, 1'b1}, '{AMD_DATA_MARK, 8'h0B, 1'b0, 1'b1, 1'b0}};
  logic i_clock, i_resetn, rclk, sdata, sclk, en, set_edge, clr_n, ready;
  logic mark, mark_n, bclk, ddata, spare, dprobe_n, cprobe_n, overrun;
  logic bclk_prev;
  logic bits_q[$];
  logic found;
  int n_rises, n_dp, n_cp, fail_count, n_checks;
  amd_separator_model sep (.o_read_clock(rclk), .o_serial_data(sdata),
    .o_serial_clock_bits(sclk));
  amd_mark_detector dut (.i_clock(i_clock), .i_resetn(i_resetn), .i_read_clock(rclk),
    .i_serial_data(sdata), .i_serial_clock_bits(sclk), .i_detect_enable(en),
    .i_spare_latch_set_edge(set_edge), .i_spare_clear_n(clr_n), .i_sink_ready(ready),
    .o_mark_found(mark), .o_mark_found_n(mark_n), .o_delayed_bit_clock(bclk),
    .o_delayed_data(ddata), .o_spare_latch_out(spare), .o_data_pattern_probe_n(dprobe_n),
    .o_clock_pattern_probe_n(cprobe_n), .o_stream_overrun(overrun));
  initial
  begin
    i_clock = 1'b0;
    forever #5 i_clock = ~i_clock;
  end
  always @(posedge i_clock)
  begin
    bclk_prev <= bclk;
    if (bclk === 1'b1 && bclk_prev === 1'b0)
    begin
      n_rises++;
      bits_q.push_back(ddata);
    end
    if (dprobe_n === 1'b0)
      n_dp++;
    if (cprobe_n === 1'b0)
      n_cp++;
  end
  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic check_bit(input logic got, input logic exp, input string msg);
    n_checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("BAD %0t %s got %b exp %b", $time, msg, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge i_clock);
    #1;
  endtask
  // Bounded wait on mark (0), spare output (1) or overrun (2)
  task automatic wait_out(input int sel, input logic exp);
    logic v;
    for (int i = 0; i < 300; i++)
    begin
      v = (sel == 0) ? mark : (sel == 1) ? spare : overrun;
      if (v === exp)
        return;
      tick(1);
    end
    fail_count++;
    $display("BAD %0t wait timed out on output %0d", $time, sel);
    complete_run();
  endtask
  task automatic enable_and_mark(input logic [7:0] d, input logic [7:0] c);
    en = 1'b1;
    tick(40);
    sep.send(8'h00, 8'h00);
    n_dp = 0;
    n_cp = 0;
    sep.send(d, c);
  endtask
  initial
  begin
    #200000;
    fail_count++;
    $display("BAD %0t run timed out", $time);
    complete_run();
  end
  initial
  begin
    i_resetn = 1'b0;
    en = 1'b0;
    set_edge = 1'b0;
    clr_n = 1'b1;
    ready = 1'b1;
    n_rises = 0;
    fail_count = 0;
    n_checks = 0;
    tick(2);
    check_bit(mark, 1'b0, "reset mark");
    check_bit(mark_n, 1'b1, "reset mark_n");
    check_bit(bclk, 1'b0, "reset bit clock");
    check_bit(spare, AMD_SPARE_RESET, "reset spare");
    check_bit(dprobe_n & cprobe_n, 1'b1, "reset probes");
    check_bit(overrun, 1'b0, "reset overrun");
    i_resetn = 1'b1;
    tick(2);
    check_bit(mark_n, 1'b1, "mark_n after release");
    // Link side stays in reset for a stretch after release
    tick(100);
    foreach (rows[k])
    begin
      enable_and_mark(rows[k].d, rows[k].c);
      sep.send(8'h00, 8'h00);
      tick(10);
      check_bit(mark, rows[k].m, "mark");
      check_bit(mark_n, ~rows[k].m, "mark_n");
      check_bit(n_dp == 1, rows[k].dp, "data probe");
      check_bit(n_cp == 1, rows[k].cp, "clock probe");
      en = 1'b0;
      tick(40);
      check_bit(mark, 1'b0, "mark cleared");
    end
    n_rises = 0;
    sep.send(AMD_DATA_MARK, AMD_CLOCK_MARK);
    sep.send(8'h00, 8'h00);
    tick(20);
    check_bit(mark, 1'b0, "mark while disabled");
    check_bit(n_rises == 0, 1'b1, "bit clock while disabled");
    check_bit(ddata, 1'b0, "data while disabled");
    bits_q.delete();
    enable_and_mark(AMD_DATA_MARK, AMD_CLOCK_MARK);
    sep.send(8'hC3, 8'h00);
    sep.send(8'h5A, 8'h00);
    sep.send(8'h00, 8'h00);
    sep.send(8'h00, 8'h00);
    check_bit(mark, 1'b1, "mark latched");
    found = 1'b0;
    for (int i = 0; i + 16 <= bits_q.size(); i++)
    begin
      logic [15:0] w;
      w = 16'h0000;
      for (int j = 0; j < 16; j++)
        w = {w[14:0], bits_q[i + j]};
      if (w === 16'hC35A)
        found = 1'b1;
    end
    check_bit(found, 1'b1, "delayed stream order");
    n_rises = 0;
    tick(64);
    check_bit(n_rises >= 7 && n_rises <= 9, 1'b1, "bit clock rate");
    en = 1'b0;
    wait_out(0, 1'b0);
    tick(30);
    n_rises = 0;
    tick(40);
    check_bit(n_rises == 0, 1'b1, "bit clock idle");
    check_bit(ddata, 1'b0, "data idle");
    // Stalled sink: more bits than the buffer holds
    ready = 1'b0;
    enable_and_mark(AMD_DATA_MARK, AMD_CLOCK_MARK);
    sep.send(8'h00, 8'h00);
    sep.send(8'hFF, 8'h00);
    wait_out(2, 1'b1);
    ready = 1'b1;
    en = 1'b0;
    wait_out(2, 1'b0);
    set_edge = 1'b1;
    wait_out(1, 1'b0);
    set_edge = 1'b0;
    tick(5);
    clr_n = 1'b0;
    wait_out(1, 1'b1);
    set_edge = 1'b1;
    tick(10);
    check_bit(spare, 1'b1, "clear beats set");
    clr_n = 1'b1;
    set_edge = 1'b0;
    tick(10);
    check_bit(spare, 1'b1, "no set without edge");
    complete_run();
  end
endmodule
